// ==== hdl/rcw_pkg.sv ====
package rcw_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [31:0] ADDR_PCLK_DIV = 32'he01fc100;
  localparam logic [31:0] ADDR_RESET_CAUSE = 32'he01fc180;
  localparam logic [7:0] PCLK_DIV_RST = 8'h00;
  localparam logic [3:0] RESET_CAUSE_POR = 4'h1;
  // ---------------------------------------------------------------
  // reset-cause field positions
  // ---------------------------------------------------------------
  localparam int BIT_POR = 0;
  localparam int BIT_PIN = 1;
  localparam int BIT_WDT = 2;
  localparam int BIT_BOD = 3;
  // ---------------------------------------------------------------
  // divider select encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] DIV_QUARTER = 2'h0;
  localparam logic [1:0] DIV_FULL = 2'h1;
  localparam logic [1:0] DIV_HALF = 2'h2;
  localparam logic [1:0] DIV_RSVD = 2'h3;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int WAKE_OSC_CLOCKS = 4096;
  typedef enum logic [2:0] {WK_HOLD, WK_COUNT, WK_INIT, WK_RUN, WK_PDOWN} rcw_state_t;
endpackage : rcw_pkg

// ==== hdl/rcw_pclk_div.sv ====
`timescale 1ns/1ns
`default_nettype none
module rcw_pclk_div
  import rcw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [1:0] sel,
  output logic pclk_en,
  output logic [1:0] active_sel
);
  // ---------------------------------------------------------------
  // ratio decode
  // ---------------------------------------------------------------
  function automatic logic [1:0] rcw_last(input logic [1:0] s);
    if (s == DIV_FULL) begin
      return 2'h0;
    end else if (s == DIV_HALF) begin
      return 2'h1;
    end else begin
      return 2'h3;
    end
  endfunction : rcw_last

  logic [1:0] cnt;
  wire logic at_edge = (cnt == rcw_last(active_sel));

  // ratio swaps only at the period end, so no runt period appears
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 2'h0;
      active_sel <= DIV_QUARTER;
      pclk_en <= 1'b0;
    end else if (at_edge) begin
      cnt <= 2'h0;
      active_sel <= sel;
      pclk_en <= 1'b1;
    end else begin
      cnt <= cnt + 2'h1;
      pclk_en <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_div_full;
    @(posedge clk_sys) disable iff (!arst_n)
      (active_sel == DIV_FULL && $past(active_sel) == DIV_FULL) |-> pclk_en;
  endproperty
  a_div_full: assert property (p_div_full) else $error("full rate enable missing");
  property p_div_quarter;
    @(posedge clk_sys) disable iff (!arst_n)
      (pclk_en && active_sel == DIV_QUARTER && sel == DIV_QUARTER) |=> !pclk_en [*3] ##1 pclk_en;
  endproperty
  a_div_quarter: assert property (p_div_quarter) else $error("quarter rate spacing wrong");
  property p_div_boundary;
    @(posedge clk_sys) disable iff (!arst_n)
      (active_sel != $past(active_sel)) |-> pclk_en;
  endproperty
  a_div_boundary: assert property (p_div_boundary) else $error("ratio changed mid period");
endmodule : rcw_pclk_div
`default_nettype wire

// ==== hdl/rcw_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module rcw_top
  import rcw_pkg::*;
#(
  parameter int WAKE_CLOCKS = WAKE_OSC_CLOCKS,
  parameter int CHANNELS = 4,
  parameter int PINS_PER_CH = 2
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  // register port
  input wire logic [31:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // reset sources
  input wire logic pin_reset_n,
  input wire logic brownout_reset,
  input wire logic watchdog_timeout,
  input wire logic watchdog_reset_enable,
  input wire logic osc_detected,
  // power management
  input wire logic pdown_req,
  input wire logic init_done,
  input wire logic pll_running,
  // wake sources
  input wire logic [CHANNELS*PINS_PER_CH-1:0] external_interrupt_lines,
  input wire logic [CHANNELS-1:0] wake_enable,
  input wire logic [CHANNELS-1:0] wake_level_mode,
  input wire logic [CHANNELS-1:0] wake_active_high,
  input wire logic rtc_irq,
  input wire logic rtc_own_osc,
  input wire logic rtc_wake_enable,
  // outputs
  output logic cpu_release,
  output logic init_enable,
  output logic osc_enable,
  output logic pll_keep_active,
  output logic [CHANNELS:0] wake_irq,
  output logic pclk_en
);
  localparam int NPIN = CHANNELS * PINS_PER_CH;
  localparam logic [12:0] WAKE_LAST = 13'(WAKE_CLOCKS - 1);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // pins and analog detectors are asynchronous to clk_sys
  logic [NPIN+3:0] sync1;
  logic [NPIN+3:0] sync2;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {rtc_irq, osc_detected, brownout_reset, ~pin_reset_n, external_interrupt_lines};
      sync2 <= sync1;
    end
  end
  wire logic [NPIN-1:0] eint_s = sync2[NPIN-1:0];
  wire logic pin_rst_s = sync2[NPIN];
  wire logic bod_s = sync2[NPIN+1];
  wire logic osc_s = sync2[NPIN+2];
  wire logic rtc_s = sync2[NPIN+3];
  wire logic wdt_fire = watchdog_timeout & watchdog_reset_enable;
  wire logic any_reset = pin_rst_s | bod_s | wdt_fire;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire logic sel_div = (reg_addr == ADDR_PCLK_DIV);
  wire logic sel_cause = (reg_addr == ADDR_RESET_CAUSE);
  wire logic wr_div = reg_wr & sel_div & (reg_wdata[1:0] != DIV_RSVD);
  wire logic [3:0] clr_mask = (reg_wr & sel_cause) ? reg_wdata[3:0] : 4'h0;

  // ---------------------------------------------------------------
  // reset-cause flags
  // ---------------------------------------------------------------
  logic [3:0] cause;
  logic [3:0] next_cause;
  // clears first, sets after, so a same-cycle event survives a write
  always_comb begin
    next_cause = cause & ~clr_mask;
    if (pin_rst_s | bod_s) begin
      next_cause[BIT_WDT] = 1'b0;
    end
    if (pin_rst_s) begin
      next_cause[BIT_PIN] = 1'b1;
    end
    if (wdt_fire) begin
      next_cause[BIT_WDT] = 1'b1;
    end
    if (bod_s) begin
      next_cause[BIT_BOD] = 1'b1;
    end
  end
  // power-on is the asynchronous reset itself
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cause <= RESET_CAUSE_POR;
    end else begin
      cause <= next_cause;
    end
  end

  // ---------------------------------------------------------------
  // divider select
  // ---------------------------------------------------------------
  logic [1:0] div_sel;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_sel <= PCLK_DIV_RST[1:0];
    end else if (any_reset) begin
      div_sel <= PCLK_DIV_RST[1:0];
    end else if (wr_div) begin
      div_sel <= reg_wdata[1:0];
    end
  end

  rcw_pclk_div u_div (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .sel(div_sel),
    .pclk_en(pclk_en),
    .active_sel()
  );

  // read data registered; reserved bits and unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (sel_div) begin
        reg_rdata <= {6'h00, div_sel};
      end else if (sel_cause) begin
        reg_rdata <= {4'h0, cause};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // wake event detection
  // ---------------------------------------------------------------
  logic [CHANNELS-1:0] pin0_prev;
  logic [CHANNELS:0] wake_hit;
  // edge mode watches only the first pin of a channel
  always_comb begin
    wake_hit = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      logic lvl;
      logic act0;
      lvl = 1'b0;
      act0 = eint_s[c*PINS_PER_CH] ~^ wake_active_high[c];
      for (int p = 0; p < PINS_PER_CH; p++) begin
        lvl = lvl | (eint_s[c*PINS_PER_CH+p] ~^ wake_active_high[c]);
      end
      wake_hit[c] = wake_enable[c] & (wake_level_mode[c] ? lvl : (act0 & ~pin0_prev[c]));
    end
    wake_hit[CHANNELS] = rtc_s & rtc_own_osc & rtc_wake_enable;
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin0_prev <= '0;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        pin0_prev[c] <= eint_s[c*PINS_PER_CH] ~^ wake_active_high[c];
      end
    end
  end

  // ---------------------------------------------------------------
  // wakeup timer state machine
  // ---------------------------------------------------------------
  rcw_state_t state;
  rcw_state_t next_state;
  logic [12:0] wake_cnt;
  logic init_seen;
  logic [CHANNELS:0] pending;
  wire logic count_done = (wake_cnt == WAKE_LAST);

  always_comb begin
    next_state = state;
    case (state)
      WK_HOLD: if (osc_s) next_state = WK_COUNT;
      WK_COUNT: if (count_done) next_state = WK_INIT;
      WK_INIT: if ((init_seen | init_done) & ~pin_rst_s) next_state = WK_RUN;
      WK_RUN: if (pdown_req) next_state = WK_PDOWN;
      WK_PDOWN: if (|wake_hit) next_state = WK_HOLD;
      default: next_state = WK_HOLD;
    endcase
    if (any_reset) begin
      next_state = WK_HOLD;
    end
  end

  // counter restarts on every entry to hold
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= WK_HOLD;
      wake_cnt <= 13'h0000;
      init_seen <= 1'b0;
    end else begin
      state <= next_state;
      wake_cnt <= (next_state == WK_COUNT && state == WK_COUNT) ? wake_cnt + 13'h0001 : 13'h0000;
      init_seen <= (next_state == WK_INIT) & (init_seen | (state == WK_INIT & init_done));
    end
  end

  // wake causes held until the timer has run out
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pending <= '0;
      wake_irq <= '0;
    end else begin
      if (state == WK_PDOWN) begin
        pending <= pending | wake_hit;
      end else if (state == WK_RUN) begin
        pending <= '0;
      end
      wake_irq <= (state == WK_INIT && next_state == WK_RUN) ? pending : '0;
    end
  end

  // outputs from flip-flops; oscillator off only in power-down
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cpu_release <= 1'b0;
      init_enable <= 1'b0;
      osc_enable <= 1'b1;
      pll_keep_active <= 1'b0;
    end else begin
      cpu_release <= (next_state == WK_RUN);
      init_enable <= (next_state == WK_INIT);
      osc_enable <= (next_state != WK_PDOWN);
      pll_keep_active <= pll_running & (next_state != WK_PDOWN);
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_w1c;
    (reg_wr && sel_cause && reg_wdata[BIT_POR]) |=> !cause[BIT_POR];
  endproperty
  a_w1c: assert property (p_w1c) else $error("power-on flag not cleared by write");
  property p_por_hold;
    !(reg_wr && sel_cause && reg_wdata[BIT_POR]) |=> cause[BIT_POR] == $past(cause[BIT_POR]);
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("power-on flag moved");
  property p_pin_flag;
    pin_rst_s |=> cause[BIT_PIN] && !cause[BIT_WDT];
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin reset flag wrong");
  property p_wdt_flag;
    (wdt_fire && !pin_rst_s && !bod_s) |=> cause[BIT_WDT];
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not set");
  property p_bod_flag;
    bod_s |=> cause[BIT_BOD] && cause[BIT_PIN] == $past(cause[BIT_PIN]) | $past(pin_rst_s);
  endproperty
  a_bod_flag: assert property (p_bod_flag) else $error("brown-out flag wrong");
  property p_div_ignore;
    (reg_wr && sel_div && reg_wdata[1:0] == DIV_RSVD && !any_reset) |=> div_sel == $past(div_sel);
  endproperty
  a_div_ignore: assert property (p_div_ignore) else $error("reserved divider value taken");
  property p_count;
    $rose(init_enable) |-> $past(state == WK_COUNT && wake_cnt == WAKE_LAST);
  endproperty
  a_count: assert property (p_count) else $error("init before full wakeup count");
  property p_release;
    $rose(cpu_release) |-> $past(state == WK_INIT && !pin_rst_s);
  endproperty
  a_release: assert property (p_release) else $error("processor released early");
  property p_reset_hold;
    any_reset |=> !cpu_release ##1 !cpu_release;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset did not hold processor");
  property p_wake;
    (state == WK_PDOWN && |wake_hit && !any_reset) |=> state == WK_HOLD && wake_cnt == 13'h0000;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not restart timer");
  property p_irq_late;
    |wake_irq |-> cpu_release && $past(state == WK_INIT);
  endproperty
  a_irq_late: assert property (p_irq_late) else $error("wake interrupt before timer expiry");
  property p_pll;
    (pll_running && state != WK_PDOWN && next_state != WK_PDOWN) |=> pll_keep_active;
  endproperty
  a_pll: assert property (p_pll) else $error("pll dropped outside power-down");

  c_pdown_wake: cover property (state == WK_PDOWN ##1 state == WK_HOLD);
  c_wdt_reset: cover property (wdt_fire ##1 cause[BIT_WDT]);
  c_irq_out: cover property (|wake_irq);
  c_div_write: cover property (wr_div && reg_wdata[1:0] == DIV_HALF);
endmodule : rcw_top
`default_nettype wire

// ==== tb/rcw_far_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module rcw_far_model #(
  parameter int PIN_CYCLES = 16,
  parameter int LINE_CYCLES = 6
) (
  input wire logic clk_sys,
  input wire logic pin_req,
  input wire logic line_req,
  input wire logic [2:0] line_idx,
  output logic pin_reset_n,
  output logic [7:0] external_interrupt_lines
);
  // ---------------------------------------------------------------
  // reset button and low-active bus lines
  // ---------------------------------------------------------------
  int pin_cnt = 0;
  int line_cnt = 0;
  logic [2:0] held_idx = 3'h0;
  // pin held low long enough to pass the pin synchroniser
  always @(posedge clk_sys) begin
    if (pin_req) begin
      pin_cnt <= PIN_CYCLES;
    end else if (pin_cnt != 0) begin
      pin_cnt <= pin_cnt - 1;
    end
  end
  // line activity is low-active; pull-ups bring it back high
  always @(posedge clk_sys) begin
    if (line_req) begin
      line_cnt <= LINE_CYCLES;
      held_idx <= line_idx;
    end else if (line_cnt != 0) begin
      line_cnt <= line_cnt - 1;
    end
  end
  assign pin_reset_n = (pin_cnt == 0);
  assign external_interrupt_lines = (line_cnt != 0) ? ~(8'h01 << held_idx) : 8'hff;
endmodule : rcw_far_model
`default_nettype wire

// ==== tb/reset_cause_clkdiv_wakeup_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module reset_cause_clkdiv_wakeup_bench;
  import rcw_pkg::*;
  localparam int WAKE = 8;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic pin_reset_n;
  logic brownout_reset = 1'b0;
  logic watchdog_timeout = 1'b0;
  logic watchdog_reset_enable = 1'b0;
  logic pdown_req = 1'b0;
  logic init_done = 1'b0;
  logic [7:0] external_interrupt_lines;
  logic [3:0] wake_enable = 4'h0;
  logic [3:0] wake_level_mode = 4'h0;
  logic rtc_irq = 1'b0;
  logic osc_detected = 1'b1;
  logic rtc_own_osc = 1'b1;
  logic cpu_release, init_enable, osc_enable, pll_keep_active, pclk_en;
  logic [4:0] wake_irq;
  logic pin_req = 1'b0;
  logic line_req = 1'b0;
  logic [2:0] line_idx = 3'h0;
  int failures = 0;
  int num_checks = 0;
  rcw_top #(.WAKE_CLOCKS(WAKE)) u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pin_reset_n(pin_reset_n), .brownout_reset(brownout_reset), .watchdog_timeout(watchdog_timeout),
    .watchdog_reset_enable(watchdog_reset_enable), .osc_detected(osc_detected), .pdown_req(pdown_req),
    .init_done(init_done), .pll_running(1'b1), .external_interrupt_lines(external_interrupt_lines),
    .wake_enable(wake_enable), .wake_level_mode(wake_level_mode), .wake_active_high(4'h0),
    .rtc_irq(rtc_irq), .rtc_own_osc(rtc_own_osc), .rtc_wake_enable(1'b1), .cpu_release(cpu_release),
    .init_enable(init_enable), .osc_enable(osc_enable), .pll_keep_active(pll_keep_active),
    .wake_irq(wake_irq), .pclk_en(pclk_en));
  rcw_far_model u_far (.clk_sys(clk_sys), .pin_req(pin_req), .line_req(line_req), .line_idx(line_idx),
    .pin_reset_n(pin_reset_n), .external_interrupt_lines(external_interrupt_lines));
  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic reg_write(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk_sys) reg_wr <= 1'b0;
  endtask : reg_write
  task automatic cause_is(input logic [7:0] exp);
    @(posedge clk_sys) {reg_addr, reg_rd} <= {ADDR_RESET_CAUSE, 1'b1};
    @(posedge clk_sys) reg_rd <= 1'b0;
    @(negedge clk_sys) check(reg_rdata, exp, "cause flags");
  endtask : cause_is
  task automatic read_is(input logic [31:0] a, input logic [7:0] exp);
    @(posedge clk_sys) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk_sys) reg_rd <= 1'b0;
    @(negedge clk_sys) check(reg_rdata, exp, "register read");
  endtask : read_is
  // counts the wakeup delay, finishes init, collects the wake pulses
  task automatic run_up(input logic [4:0] exp_irq);
    int n;
    logic [4:0] early;
    logic [4:0] irqs;
    n = 0;
    early = 5'h0;
    irqs = 5'h0;
    do begin @(negedge clk_sys); early |= wake_irq; n++; end while (init_enable !== 1'b1 && n < 60);
    check({7'h0, n > WAKE && n < 60}, 8'h01, "wakeup delay");
    check({3'h0, early}, 8'h00, "irq before expiry");
    check({7'h0, cpu_release}, 8'h00, "release before init");
    @(posedge clk_sys) init_done <= 1'b1;
    @(posedge clk_sys) init_done <= 1'b0;
    n = 0;
    do begin @(negedge clk_sys); irqs |= wake_irq; n++; end while (cpu_release !== 1'b1 && n < 10);
    check({7'h0, cpu_release}, 8'h01, "release after init");
    check({3'h0, irqs}, {3'h0, exp_irq}, "wake pulses");
  endtask : run_up
  // first pulse may still be of the old ratio, the second is the swap, the third is measured
  task automatic pclk_is(input int exp);
    int n;
    repeat (3) begin
      n = 0;
      do begin @(negedge clk_sys); n++; end while (pclk_en !== 1'b1 && n < 9);
    end
    check(n[7:0], exp[7:0], "pclk period");
  endtask : pclk_is
  task automatic pdown;
    @(posedge clk_sys) pdown_req <= 1'b1;
    @(posedge clk_sys) pdown_req <= 1'b0;
    repeat (6) @(negedge clk_sys);
    check({6'h0, osc_enable, pll_keep_active}, 8'h00, "power-down outputs");
  endtask : pdown
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // wakeup delay is measured from the release of reset itself
  task automatic t_reset;
    run_up(5'h00);
    cause_is(8'h01);
    read_is(ADDR_PCLK_DIV, 8'h00);
    read_is(32'he01fc104, 8'h00);
    check({7'h0, pll_keep_active}, 8'h01, "pll kept");
    $display("done reset values");
  endtask : t_reset
  task automatic t_divider;
    pclk_is(4);
    reg_write(ADDR_PCLK_DIV, {6'h0, DIV_FULL});
    pclk_is(1);
    reg_write(ADDR_PCLK_DIV, {6'h0, DIV_HALF});
    pclk_is(2);
    reg_write(ADDR_PCLK_DIV, {6'h0, DIV_RSVD});
    pclk_is(2);
    read_is(ADDR_PCLK_DIV, {6'h0, DIV_HALF});
    reg_write(ADDR_PCLK_DIV, {6'h0, DIV_QUARTER});
    pclk_is(4);
    $display("done divider");
  endtask : t_divider
  task automatic t_sources;
    @(posedge clk_sys) watchdog_timeout <= 1'b1;
    @(posedge clk_sys) watchdog_timeout <= 1'b0;
    repeat (6) @(negedge clk_sys);
    check({7'h0, cpu_release}, 8'h01, "disabled watchdog");
    cause_is(8'h01);
    @(posedge clk_sys) {watchdog_reset_enable, watchdog_timeout} <= 2'h3;
    @(posedge clk_sys) watchdog_timeout <= 1'b0;
    run_up(5'h00);
    cause_is(8'h05);
    @(posedge clk_sys) pin_req <= 1'b1;
    @(posedge clk_sys) pin_req <= 1'b0;
    run_up(5'h00);
    cause_is(8'h03);
    @(posedge clk_sys) brownout_reset <= 1'b1;
    repeat (6) @(posedge clk_sys);
    brownout_reset <= 1'b0;
    run_up(5'h00);
    cause_is(8'h0b);
    reg_write(ADDR_RESET_CAUSE, 8'h01);
    cause_is(8'h0a);
    reg_write(ADDR_RESET_CAUSE, 8'h00);
    cause_is(8'h0a);
    reg_write(ADDR_RESET_CAUSE, 8'h0a);
    cause_is(8'h00);
    @(posedge clk_sys) watchdog_timeout <= 1'b1;
    @(posedge clk_sys) watchdog_timeout <= 1'b0;
    run_up(5'h00);
    cause_is(8'h04);
    $display("done reset sources");
  endtask : t_sources
  // pins moved to interrupt use: channel 0 low level, channel 1 falling edge
  task automatic t_wake;
    @(posedge clk_sys) {wake_enable, wake_level_mode} <= {4'h3, 4'h1};
    pdown;
    @(posedge clk_sys) {line_idx, line_req} <= {3'h1, 1'b1};
    @(posedge clk_sys) line_req <= 1'b0;
    run_up(5'h01);
    pdown;
    @(posedge clk_sys) {line_idx, line_req} <= {3'h3, 1'b1};
    @(posedge clk_sys) line_req <= 1'b0;
    repeat (12) @(negedge clk_sys);
    check({7'h0, osc_enable}, 8'h00, "edge mode shared pin");
    @(posedge clk_sys) {line_idx, line_req} <= {3'h2, 1'b1};
    @(posedge clk_sys) line_req <= 1'b0;
    run_up(5'h02);
    pdown;
    @(posedge clk_sys) {rtc_own_osc, rtc_irq} <= 2'h1;
    repeat (12) @(negedge clk_sys);
    check({7'h0, osc_enable}, 8'h00, "rtc without own oscillator");
    @(posedge clk_sys) rtc_own_osc <= 1'b1;
    run_up(5'h10);
    @(posedge clk_sys) rtc_irq <= 1'b0;
    $display("done wakeup");
  endtask : t_wake
  task automatic t_por_pin;
    @(posedge clk_sys) pin_req <= 1'b1;
    @(posedge clk_sys) {pin_req, arst_n, osc_detected} <= 3'h0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (30) @(negedge clk_sys);
    check({7'h0, init_enable}, 8'h00, "init without oscillator");
    @(posedge clk_sys) osc_detected <= 1'b1;
    run_up(5'h00);
    cause_is(8'h03);
    $display("done power-on with pin held");
  endtask : t_por_pin
  // bounded run in case a wait never ends
  initial begin
    #(100 * 6000);
    failures++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset;
    t_divider;
    t_sources;
    t_wake;
    t_por_pin;
    give_verdict;
  end
endmodule : reset_cause_clkdiv_wakeup_bench
`default_nettype wire
